/* File: bench/pad_partner.sv */
// board-side model of the devices wired to the two pads
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  // clock
  input  wire logic       i_mclk,
  // cell side of the pads
  input  wire logic [1:0] i_pad_out,
  input  wire logic [1:0] i_pad_oe_n,
  // board device drive enable and value
  input  wire logic [1:0] i_drv,
  input  wire logic [1:0] i_val,
  // resolved pad level seen by the cell
  output logic [1:0]      o_pad_in
);
  logic [1:0] last = 2'h0;  // last resolved level
  // cell wins where it drives, then the board device
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!i_pad_oe_n[i]) begin
        o_pad_in[i] = i_pad_out[i];
      end else if (i_drv[i]) begin
        o_pad_in[i] = i_val[i];
      end else begin
        // nobody drives: a floating pad keeps no value
        o_pad_in[i] = ~last[i];
      end
    end
  end
  // remember the level so a float drifts every cycle
  always_ff @(posedge i_mclk) begin
    last <= o_pad_in;
  end
endmodule
`default_nettype wire

/* File: bench/tb_io_pair_register_ddr_cell.sv */
// self-checking bench for the two-pad register/double-rate cell
`timescale 1ns/1ps
`default_nettype none
module tb_io_pair_register_ddr_cell;
  // cell inputs and outputs
  logic                         i_mclk = 1'b0;
  logic                         i_nrst;
  logic                         i_input_capture_clock;
  logic                         i_output_launch_clock;
  logic                         i_pair_clock_enable;
  io_pair_pkg::pad_cfg_t [1:0]  i_pad_cfg;
  io_pair_pkg::pair_cfg_t       i_pair_cfg;
  logic [1:0]                   i_fabric_out;
  logic [1:0]                   i_fabric_oe;
  logic                         i_word_valid;
  io_pair_pkg::out_word_t       i_word;
  logic                         o_word_ready;
  logic [1:0]                   i_pad_in;
  logic [1:0]                   o_pad_out;
  logic [1:0]                   o_pad_oe_n;
  logic [1:0]                   o_in_rise;
  logic [1:0]                   o_in_fall;
  // board device controls and counters
  logic [1:0]                   drv;
  logic [1:0]                   val;
  int                           err_count = 0;
  int                           cmp_count = 0;
  io_pair_pkg::out_word_t       wl [3] = '{6'h13, 6'h21, 6'h32};

  // system clock, 5 ns period
  always #2.5 i_mclk = ~i_mclk;

  io_pair_register_ddr_cell DUT (
    .i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_input_capture_clock(i_input_capture_clock),
    .i_output_launch_clock(i_output_launch_clock),
    .i_pair_clock_enable(i_pair_clock_enable),
    .i_pad_cfg(i_pad_cfg), .i_pair_cfg(i_pair_cfg),
    .i_fabric_out(i_fabric_out), .i_fabric_oe(i_fabric_oe),
    .i_word_valid(i_word_valid), .i_word(i_word),
    .o_word_ready(o_word_ready), .i_pad_in(i_pad_in),
    .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n),
    .o_in_rise(o_in_rise), .o_in_fall(o_in_fall));

  pad_partner pads (
    .i_mclk(i_mclk), .i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n),
    .i_drv(drv), .i_val(val), .o_pad_in(i_pad_in));

  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one value against its expectation
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait whole cycles, ending on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // pair clock levels, held long enough for an edge to land
  task automatic lclk(input logic v);
    i_output_launch_clock = v;
    cyc(3);
  endtask
  task automatic cclk(input logic v);
    i_input_capture_clock = v;
    cyc(3);
  endtask
  // both pair clocks from one source
  task automatic bclk(input logic v);
    i_input_capture_clock = v;
    i_output_launch_clock = v;
    cyc(3);
  endtask

  // offer one launch word and hold it until taken
  task automatic push(input io_pair_pkg::out_word_t w);
    int k;
    k = 0;
    i_word_valid = 1'b1;
    i_word = w;
    while (o_word_ready !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    if (o_word_ready !== 1'b1) begin
      err_count++;
      finish_test();
    end
    cyc(1);
    // lower valid and let an edge pass before the next offer
    i_word_valid = 1'b0;
    cyc(1);
  endtask

  // end-of-test line
  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  // hang guard
  initial begin
    #200000;
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    i_nrst = 1'b0;
    i_input_capture_clock = 1'b0;
    i_output_launch_clock = 1'b0;
    i_pair_clock_enable = 1'b0;
    i_pad_cfg[1] = 8'hC0;
    i_pad_cfg[0] = 8'h00;
    i_pair_cfg = 2'h0;
    i_fabric_out = 2'h1;
    i_fabric_oe = 2'h3;
    i_word_valid = 1'b0;
    i_word = 6'h00;
    drv = 2'h0;
    val = 2'h0;
    cyc(10);
    i_nrst = 1'b1;
    cyc(4);
    // reset state, direct paths and forced drivers
    chk(o_pad_out, 2'h3);
    chk(o_pad_oe_n, 2'h0);
    chk(o_word_ready, 1'b1);
    chk(o_in_fall, 2'h0);
    i_fabric_oe = 2'h2;
    i_fabric_out = 2'h0;
    drv = 2'h1;
    val = 2'h1;
    cyc(1);
    chk(o_pad_oe_n, 2'h1);
    chk(o_in_rise, 2'h3);
    i_pad_cfg[1] = 8'h04;
    i_pad_cfg[0] = 8'h08;
    for (int k = 0; k < 4; k++) begin
      i_fabric_oe = 2'(k);
      cyc(1);
      chk(o_pad_oe_n, 2'h2);
    end
    done("direct");
    // registered launch, buffer refusal, clock enable, fifo order
    i_pad_cfg[1] = 8'h90;
    i_pad_cfg[0] = 8'h90;
    i_pair_cfg = 2'h1;
    i_pair_clock_enable = 1'b1;
    i_fabric_out = 2'h3;
    i_fabric_oe = 2'h3;
    drv = 2'h0;
    cyc(1);
    chk(o_pad_out, 2'h0);
    chk(o_pad_oe_n, 2'h3);
    push(wl[0]);
    push(wl[1]);
    i_word = wl[2];
    i_word_valid = 1'b1;
    cyc(2);
    chk(o_word_ready, 1'b0);
    i_pair_clock_enable = 1'b0;
    lclk(1'b1);
    lclk(1'b0);
    chk(o_pad_out, 2'h0);
    chk(o_word_ready, 1'b0);
    i_pair_clock_enable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      lclk(1'b1);
      chk(o_pad_out, wl[i].rise);
      chk(o_pad_oe_n, ~wl[i].oe);
      if (i == 0) begin
        // the held word went in once a slot opened
        i_word_valid = 1'b0;
        chk(o_word_ready, 1'b0);
      end
      lclk(1'b0);
    end
    lclk(1'b1);
    cclk(1'b1);
    cclk(1'b0);
    chk(o_pad_out, 2'h3);
    chk(o_word_ready, 1'b1);
    lclk(1'b0);
    done("registered");
    // double-rate launch, inversion, clock polarity swap
    i_pad_cfg[0] = 8'h30;
    i_pad_cfg[1] = 8'h70;
    i_pair_cfg = 2'h0;
    push(6'h1B);
    lclk(1'b1);
    chk(o_pad_out, 2'h3);
    lclk(1'b0);
    chk(o_pad_out, 2'h0);
    chk(o_pad_oe_n, 2'h0);
    i_pair_cfg = 2'h2;
    cyc(3);
    chk(o_pad_out, 2'h3);
    push(6'h37);
    lclk(1'b1);
    chk(o_pad_out, 2'h0);
    lclk(1'b0);
    chk(o_pad_out, 2'h1);
    lclk(1'b1);
    chk(o_pad_out, 2'h3);
    done("ddr out");
    // double-rate and registered capture
    i_pad_cfg[0] = 8'h05;
    i_pad_cfg[1] = 8'h05;
    drv = 2'h3;
    val = 2'h2;
    cclk(1'b1);
    chk(o_in_fall, 2'h2);
    val = 2'h1;
    cclk(1'b0);
    chk(o_in_rise, 2'h1);
    chk(o_pad_oe_n, 2'h3);
    i_pair_cfg = 2'h0;
    cyc(3);
    chk(o_in_fall, 2'h1);
    val = 2'h2;
    cclk(1'b1);
    chk(o_in_rise, 2'h2);
    val = 2'h3;
    lclk(1'b0);
    lclk(1'b1);
    chk(o_in_rise, 2'h2);
    chk(o_in_fall, 2'h1);
    cclk(1'b0);
    chk(o_in_fall, 2'h3);
    i_pad_cfg[0] = 8'h06;
    i_pad_cfg[1] = 8'h06;
    val = 2'h0;
    cyc(2);
    chk(o_in_rise, 2'h2);
    cclk(1'b1);
    chk(o_in_rise, 2'h0);
    done("capture");
    // mid-run reset returns every register to its start value
    i_nrst = 1'b0;
    cyc(2);
    chk(o_in_rise, 2'h0);
    chk(o_in_fall, 2'h0);
    chk(o_word_ready, 1'b1);
    i_nrst = 1'b1;
    cyc(4);
    chk(o_in_fall, 2'h0);
    done("reset");
    // capture and launch driven by one shared clock
    i_pad_cfg[0] = 8'h91;
    i_pad_cfg[1] = 8'h91;
    drv = 2'h3;
    val = 2'h1;
    bclk(1'b0);
    push(6'h3F);
    bclk(1'b1);
    chk(o_in_rise, 2'h1);
    chk(o_pad_oe_n, 2'h0);
    chk(o_pad_out, 2'h3);
    bclk(1'b0);
    chk(o_in_fall, 2'h3);
    done("tied clocks");
    finish_test();
  end
endmodule
`default_nettype wire

/* File: hdl/clk_edge.sv */
// edge detector for a pair clock sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module clk_edge (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // sampled pair clock and polarity
  input  wire logic i_level,
  input  wire logic i_invert,
  // effective level and one-cycle edge pulses
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  io_pair_pkg::edge_state_t state;       // registered state
  io_pair_pkg::edge_state_t next_state;  // next value

  // polarity applied before edges are found
  assign o_level = i_level ^ i_invert;
  assign o_rise  = o_level & ~state.prev;
  assign o_fall  = ~o_level & state.prev;

  // remember the level
  always_comb begin
    next_state      = state;
    next_state.prev = o_level;
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= io_pair_pkg::EDGE_RESET;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/io_pair_pkg.sv */
// shared types and constants for the two-pad register/double-rate cell
package io_pair_pkg;

  // pads per pair and depth of the launch buffer
  localparam int unsigned NUM_PADS  = 2;
  localparam int unsigned BUF_DEPTH = 2;

  // static per-pad configuration, fixed while the cell runs
  typedef struct packed {
    logic out_registered;  // pad data passes through the launch register
    logic out_invert;      // invert after the launch register
    logic out_ddr;         // double-rate launch pair drives the pad
    logic oe_registered;   // drive enable passes through its own register
    logic oe_force_on;     // driver on unless oe_force_off is set (output-only pad)
    logic oe_force_off;    // driver always off (input-only pad)
    logic in_registered;   // pad value held in the capture register
    logic in_ddr;          // double-rate capture pair in use
  } pad_cfg_t;

  // static configuration shared by both pads
  typedef struct packed {
    logic clk_invert;      // swap the edges of both pair clocks
    logic ce_used;         // pair clock enable is wired up
  } pair_cfg_t;

  // one launch word: rise data, fall data and drive enable per pad
  typedef struct packed {
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] oe;
  } out_word_t;

  // state of the two-entry launch buffer
  typedef struct packed {
    out_word_t [1:0] mem;  // storage
    logic            wr_ptr;
    logic            rd_ptr;
    logic [1:0]      count;
  } buf_state_t;

  // state of a sampled-clock edge detector
  typedef struct packed {
    logic prev;            // level seen one cycle earlier
  } edge_state_t;

  // register state of the cell
  typedef struct packed {
    out_word_t  cur;       // word taken at the last launch rise
    logic [1:0] out_rise;  // launch register, rising edge
    logic [1:0] out_fall;  // launch register, falling edge
    logic [1:0] oe_q;      // drive-enable register
    logic [1:0] in_rise;   // capture register, rising edge
    logic [1:0] in_fall;   // capture register, falling edge
  } cell_state_t;

  // values after reset, and the full and empty buffer fill counts
  localparam buf_state_t  BUF_RESET  = 16'h0000;
  localparam edge_state_t EDGE_RESET = 1'h0;
  localparam cell_state_t CELL_RESET = 16'h0000;
  localparam logic [1:0]  BUF_FULL   = 2'h2;
  localparam logic [1:0]  BUF_EMPTY  = 2'h0;

endpackage

/* File: hdl/io_pair_register_ddr_cell.sv */
// two-pad programmable cell with registered and double-rate paths
`timescale 1ns/1ps
`default_nettype none
module io_pair_register_ddr_cell (
  // system clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_nrst,
  // pair clocks and enable, sampled on the system clock
  input  wire logic                         i_input_capture_clock,
  input  wire logic                         i_output_launch_clock,
  input  wire logic                         i_pair_clock_enable,
  // static configuration
  input  wire io_pair_pkg::pad_cfg_t [1:0]  i_pad_cfg,
  input  wire io_pair_pkg::pair_cfg_t       i_pair_cfg,
  // fabric direct paths for unregistered modes
  input  wire logic [1:0]                   i_fabric_out,
  input  wire logic [1:0]                   i_fabric_oe,
  // fabric launch word stream
  input  wire logic                         i_word_valid,
  input  wire io_pair_pkg::out_word_t       i_word,
  output logic                              o_word_ready,
  // pads
  input  wire logic [1:0]                   i_pad_in,
  output logic [1:0]                        o_pad_out,
  output logic [1:0]                        o_pad_oe_n,
  // fabric input data
  output logic [1:0]                        o_in_rise,
  output logic [1:0]                        o_in_fall
);

  logic [1:0]               rst_sync;    // reset release synchroniser
  logic                     rst_n;       // synchronised reset
  io_pair_pkg::cell_state_t state;       // registered state
  io_pair_pkg::cell_state_t next_state;  // next value
  logic                     ce_eff;      // effective pair enable
  logic                     cap_level;   // effective capture level
  logic                     cap_rise;    // capture rising event
  logic                     cap_fall;    // capture falling event
  logic                     lau_level;   // effective launch level
  logic                     lau_rise;    // launch rising event
  logic                     lau_fall;    // launch falling event
  logic                     buf_valid;   // buffer holds a word
  io_pair_pkg::out_word_t   buf_word;    // head word of the buffer
  logic                     lau_take;    // launch edge asks for a word
  logic                     lau_load;    // word taken into registers

  // reset released through two flops
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // enable is always on when not wired up
  assign ce_eff = ~i_pair_cfg.ce_used | i_pair_clock_enable;

  // capture clock edges, polarity shared by the pair
  clk_edge u_cap_edge (
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_level  (i_input_capture_clock),
    .i_invert (i_pair_cfg.clk_invert),
    .o_level  (cap_level),
    .o_rise   (cap_rise),
    .o_fall   (cap_fall)
  );

  // launch clock edges; may be the same source as capture
  clk_edge u_lau_edge (
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_level  (i_output_launch_clock),
    .i_invert (i_pair_cfg.clk_invert),
    .o_level  (lau_level),
    .o_rise   (lau_rise),
    .o_fall   (lau_fall)
  );

  // a stalled launch clock back-pressures the fabric stream
  assign lau_take = ce_eff & lau_rise;
  assign lau_load = lau_take & buf_valid;

  pair_buffer u_buf (
    .i_mclk   (i_mclk),
    .i_rst_n  (rst_n),
    .i_valid  (i_word_valid),
    .i_word   (i_word),
    .o_ready  (o_word_ready),
    .o_valid  (buf_valid),
    .o_word   (buf_word),
    .i_ready  (lau_take)
  );

  // register loads, one shared enable for both pads
  always_comb begin
    next_state = state;
    // launch rise loads data and enable registers
    if (lau_load) begin
      next_state.cur      = buf_word;
      next_state.out_rise = buf_word.rise;
      next_state.oe_q     = buf_word.oe;
    end
    // launch fall loads the second half of the word
    if (ce_eff && lau_fall) begin
      next_state.out_fall = state.cur.fall;
    end
    // capture clock touches input registers only
    if (ce_eff && cap_rise) begin
      next_state.in_rise = i_pad_in;
    end
    if (ce_eff && cap_fall) begin
      next_state.in_fall = i_pad_in;
    end
  end

  // every register starts from reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= io_pair_pkg::CELL_RESET;
    end else begin
      state <= next_state;
    end
  end

  // pad drivers and fabric input selection, per pad
  always_comb begin
    logic pre;
    logic oe;
    pre = 1'h0;
    oe  = 1'h0;
    o_pad_out  = 2'h0;
    o_pad_oe_n = 2'h3;
    o_in_rise  = 2'h0;
    o_in_fall  = 2'h0;
    for (int p = 0; p < 2; p++) begin
      // data path choice
      if (i_pad_cfg[p].out_ddr) begin
        pre = lau_level ? state.out_rise[p] : state.out_fall[p];
      end else if (i_pad_cfg[p].out_registered) begin
        pre = state.out_rise[p];
      end else begin
        pre = i_fabric_out[p];
      end
      // inversion only behind a register
      if (i_pad_cfg[p].out_invert &&
          (i_pad_cfg[p].out_registered || i_pad_cfg[p].out_ddr)) begin
        o_pad_out[p] = ~pre;
      end else begin
        o_pad_out[p] = pre;
      end
      // drive enable: forces win over the dynamic enable
      if (i_pad_cfg[p].oe_force_off) begin
        oe = 1'h0;
      end else if (i_pad_cfg[p].oe_force_on) begin
        oe = 1'h1;
      end else if (i_pad_cfg[p].oe_registered) begin
        oe = state.oe_q[p];
      end else begin
        oe = i_fabric_oe[p];
      end
      o_pad_oe_n[p] = ~oe;  // low enable floats the pad
      // input path choice
      if (i_pad_cfg[p].in_registered || i_pad_cfg[p].in_ddr) begin
        o_in_rise[p] = state.in_rise[p];
      end else begin
        o_in_rise[p] = i_pad_in[p];
      end
      o_in_fall[p] = state.in_fall[p];
    end
  end

  // pad checks on pad 0, register checks on both pads; pad 1 shares the same logic
  a_force_off_float: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    i_pad_cfg[0].oe_force_off |-> o_pad_oe_n[0])
    else $error("forced-off pad is driven");

  a_force_on_drive: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (i_pad_cfg[0].oe_force_on && !i_pad_cfg[0].oe_force_off)
      |-> !o_pad_oe_n[0])
    else $error("forced-on pad is not driven");

  a_oe_direct_path: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (!i_pad_cfg[0].oe_registered && !i_pad_cfg[0].oe_force_on &&
     !i_pad_cfg[0].oe_force_off) |-> (o_pad_oe_n[0] == !i_fabric_oe[0]))
    else $error("direct enable not followed");

  a_oe_reg_launch: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (ce_eff && lau_rise && buf_valid && i_pad_cfg[0].oe_registered &&
     !i_pad_cfg[0].oe_force_on && !i_pad_cfg[0].oe_force_off &&
     $stable(i_pad_cfg[0]))
      |=> (o_pad_oe_n[0] == !$past(buf_word.oe[0])))
    else $error("registered enable not loaded at launch rise");

  a_out_bypass: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (!i_pad_cfg[0].out_registered && !i_pad_cfg[0].out_ddr)
      |-> (o_pad_out[0] == i_fabric_out[0]))
    else $error("bypass output differs from fabric");

  a_out_invert: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (i_pad_cfg[0].out_registered && !i_pad_cfg[0].out_ddr &&
     i_pad_cfg[0].out_invert) |-> (o_pad_out[0] == !state.out_rise[0]))
    else $error("inverted register output wrong");

  a_ddr_mux_level: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (i_pad_cfg[0].out_ddr && !i_pad_cfg[0].out_invert)
      |-> (o_pad_out[0] ==
           (lau_level ? state.out_rise[0] : state.out_fall[0])))
    else $error("double-rate mux picks wrong register");

  a_ddr_fall_load: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (ce_eff && lau_fall) |=> (state.out_fall == $past(state.cur.fall)))
    else $error("fall launch register not loaded");

  a_in_rise_cap: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (ce_eff && cap_rise) |=> (state.in_rise == $past(i_pad_in)))
    else $error("rise capture missed");

  a_in_fall_cap: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (ce_eff && cap_fall && i_pad_cfg[0].in_ddr && $stable(i_pad_cfg[0]))
      |=> (o_in_fall[0] == $past(i_pad_in[0])))
    else $error("fall capture not presented");

  a_ce_holds_all: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    !ce_eff |=> (state == $past(state)))
    else $error("register moved while enable low");

  a_cap_no_output: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (!lau_rise && !lau_fall) |=> (state.out_rise == $past(state.out_rise) &&
                                  state.oe_q == $past(state.oe_q)))
    else $error("output register moved without launch edge");

  a_reset_leave: assert property (
    @(posedge i_mclk)
    (rst_n && !$past(rst_n)) |-> (state == io_pair_pkg::CELL_RESET))
    else $error("registers not in reset state at release");

  a_rise_launch_load: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    lau_load |=> (state.out_rise == $past(buf_word.rise)))
    else $error("rise launch register not loaded");

  a_cap_regs_hold: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (!cap_rise && !cap_fall) |=> (state.in_rise == $past(state.in_rise) &&
                                  state.in_fall == $past(state.in_fall)))
    else $error("capture register moved without capture edge");

  a_in_direct_path: assert property (
    @(posedge i_mclk) disable iff (!rst_n)
    (!i_pad_cfg[0].in_registered && !i_pad_cfg[0].in_ddr)
      |-> (o_in_rise[0] == i_pad_in[0]))
    else $error("direct input path differs from pad");

  c_ddr_out: cover property (
    @(posedge i_mclk) disable iff (!rst_n)
    i_pad_cfg[0].out_ddr && lau_load ##[1:20] (ce_eff && lau_fall));

  c_ddr_in: cover property (
    @(posedge i_mclk) disable iff (!rst_n)
    (ce_eff && cap_rise) ##[1:20] (ce_eff && cap_fall));

  c_buf_full: cover property (
    @(posedge i_mclk) disable iff (!rst_n)
    !o_word_ready ##1 lau_load);

  c_ce_stall: cover property (
    @(posedge i_mclk) disable iff (!rst_n)
    i_pair_cfg.ce_used && !i_pair_clock_enable && lau_rise);

endmodule
`default_nettype wire

/* File: hdl/pair_buffer.sv */
// two-entry buffer between fabric word source and the launch registers
`timescale 1ns/1ps
`default_nettype none
module pair_buffer (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // filling side
  input  wire logic                  i_valid,
  input  wire io_pair_pkg::out_word_t i_word,
  output logic                       o_ready,
  // draining side
  output logic                       o_valid,
  output io_pair_pkg::out_word_t     o_word,
  input  wire logic                  i_ready
);

  io_pair_pkg::buf_state_t state;       // registered state
  io_pair_pkg::buf_state_t next_state;  // next value
  logic                    push;        // word accepted
  logic                    pop;         // word handed on

  // handshake flags straight from the fill count
  assign o_ready = (state.count != io_pair_pkg::BUF_FULL);
  assign o_valid = (state.count != io_pair_pkg::BUF_EMPTY);
  assign o_word  = state.mem[state.rd_ptr];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = i_word;
      next_state.wr_ptr            = ~state.wr_ptr;
    end
    if (pop) begin
      next_state.rd_ptr = ~state.rd_ptr;
    end
    if (push && !pop) begin
      next_state.count = state.count + 2'h1;
    end else if (pop && !push) begin
      next_state.count = state.count - 2'h1;
    end
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= io_pair_pkg::BUF_RESET;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire
